// file: logic/ledctl_top.sv
// first network-status led controller with its control register
// Behaviour
// - force enable makes the led follow only the force selection.
// - force selection 11 blinks mode 2, 10 blinks mode 1, 01 on, 00 off.
// - indication bit set: qualified traffic blinks whether or not the led is on; clear: only when the led was already on.
// - full-duplex-on lights the led while link is up in full duplex with no blink.
// - half-duplex-on lights the led while link is up in half duplex with no blink.
// - transmit blink enable blinks mode 2 on tx activity when qualified.
// - receive blink enable blinks mode 2 on rx activity when qualified.
// - transmit-on lights the led on tx activity for at least 10 ms.
// - receive-on lights the led on rx activity for at least 10 ms.
// - fast-speed-on lights the led while link is up at 100 Mbps.
// - slow-speed-on lights the led while link is up at 10 Mbps.
// - collision blink enable blinks the led on collision with link up.
// - fast-speed blink enable blinks the led while link is up at 100 Mbps.
// - slow-speed blink enable blinks the led while link is up at 10 Mbps.
// - in link-good-check with phy active the led follows the link try bit.
// - blink mode 1 rate comes from bits 11:8, mode 2 from bits 7:4 of the blink register.
`timescale 1ns/100ps
`default_nettype none
`include "ledctl_consts.svh"
module ledctl_top
  import ledctl_pkg::*;
#(
  parameter int STRETCH_CYC = `LEDCTL_STRETCH_CYC,
  parameter int BLINK_BASE_CYC = `LEDCTL_BLINK_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [`LEDCTL_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // phy state
  input wire ledctl_phy_s phy_in,
  // led pin
  output logic led
);
  logic [15:0] ctrl;
  logic [15:0] blink_cfg;
  ledctl_phy_s phy_meta;
  ledctl_phy_s phy;
  logic [31:0] tx_stretch;
  logic [31:0] rx_stretch;
  logic wave1;
  logic wave2;
  logic link_fast;
  logic link_slow;
  logic on_cond;
  logic any_speed_dup_on;
  logic act_blk_qual;
  logic tx_blk;
  logic rx_blk;
  logic blink_act;
  logic blink_wave;
  logic next_led;
  ledctl_src_e src;
  ledctl_src_e next_src;
  ledctl_force_e force_sel;
  logic [31:0] tx_since;
  logic [31:0] rx_since;

  function automatic logic [31:0] stretch_next(input logic act, input logic [31:0] cnt);
    if (act) begin
      stretch_next = 32'(STRETCH_CYC);
    end else if (cnt != 32'h00000000) begin
      stretch_next = cnt - 32'd1;
    end else begin
      stretch_next = 32'h00000000;
    end
  endfunction

  function automatic logic [31:0] since_next(input logic act, input logic [31:0] cnt);
    if (act) begin
      since_next = 32'h00000000;
    end else if (cnt != 32'hffffffff) begin
      since_next = cnt + 32'd1;
    end else begin
      since_next = cnt;
    end
  endfunction

  // phy state comes from other logic whose clock we do not share
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_meta <= '0;
      phy <= '0;
    end else begin
      phy_meta <= phy_in;
      phy <= phy_meta;
    end
  end

  // register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `LEDCTL_CTRL_RESET;
      blink_cfg <= `LEDCTL_BLINK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `LEDCTL_OFF_CTRL) begin
        ctrl <= reg_wdata;
      end else if (reg_addr == `LEDCTL_OFF_BLINK) begin
        blink_cfg <= reg_wdata;
      end
    end
  end

  // register reads, unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `LEDCTL_OFF_CTRL) begin
        reg_rdata <= ctrl;
      end else if (reg_addr == `LEDCTL_OFF_BLINK) begin
        reg_rdata <= blink_cfg;
      end else if (reg_addr == `LEDCTL_OFF_STATUS) begin
        reg_rdata <= {11'h000, (tx_stretch != 32'h0), (rx_stretch != 32'h0), src, led};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // activity stretch counters reload on every activity cycle with link up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_stretch <= 32'h00000000;
      rx_stretch <= 32'h00000000;
    end else begin
      tx_stretch <= stretch_next(phy.link_up & phy.tx_active, tx_stretch);
      rx_stretch <= stretch_next(phy.link_up & phy.rx_active, rx_stretch);
    end
  end

  // cycles since the last counted activity, kept only for the on-time checks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_since <= 32'hffffffff;
      rx_since <= 32'hffffffff;
    end else begin
      tx_since <= since_next(phy.link_up & phy.tx_active, tx_since);
      rx_since <= since_next(phy.link_up & phy.rx_active, rx_since);
    end
  end

  ledctl_blink_gen #(.BASE_CYC(BLINK_BASE_CYC)) u_blink1 (
    .clk(clk),
    .rst_b(rst_b),
    .freq_sel(blink_cfg[`LEDCTL_FREQ1_HI:`LEDCTL_FREQ1_LO]),
    .wave(wave1)
  );

  ledctl_blink_gen #(.BASE_CYC(BLINK_BASE_CYC)) u_blink2 (
    .clk(clk),
    .rst_b(rst_b),
    .freq_sel(blink_cfg[`LEDCTL_FREQ2_HI:`LEDCTL_FREQ2_LO]),
    .wave(wave2)
  );

  always_comb begin
    force_sel = ledctl_force_e'(ctrl[`LEDCTL_BIT_FORCE_HI:`LEDCTL_BIT_FORCE_LO]);
    link_fast = phy.link_up & phy.fast_speed;
    link_slow = phy.link_up & ~phy.fast_speed;
    on_cond = (ctrl[`LEDCTL_BIT_FDX_ON] & phy.link_up & phy.full_duplex)
      | (ctrl[`LEDCTL_BIT_HDX_ON] & phy.link_up & ~phy.full_duplex)
      | (ctrl[`LEDCTL_BIT_TX_ON] & (tx_stretch != 32'h0))
      | (ctrl[`LEDCTL_BIT_RX_ON] & (rx_stretch != 32'h0))
      | (ctrl[`LEDCTL_BIT_FAST_ON] & link_fast)
      | (ctrl[`LEDCTL_BIT_SLOW_ON] & link_slow);
    any_speed_dup_on = (ctrl[`LEDCTL_BIT_FDX_ON] & phy.link_up & phy.full_duplex)
      | (ctrl[`LEDCTL_BIT_HDX_ON] & phy.link_up & ~phy.full_duplex)
      | (ctrl[`LEDCTL_BIT_FAST_ON] & link_fast)
      | (ctrl[`LEDCTL_BIT_SLOW_ON] & link_slow);
    // bit 13 set, or a speed/duplex on condition currently lit
    act_blk_qual = ctrl[`LEDCTL_BIT_FORCE_LO] | any_speed_dup_on;
    // indication bit set: qualified traffic blinks, lit or not; clear: only over a lit led
    if (!ctrl[`LEDCTL_BIT_ACT_IND]) begin
      act_blk_qual = act_blk_qual & on_cond;
    end
    tx_blk = ctrl[`LEDCTL_BIT_TX_BLK] & phy.link_up & phy.tx_active & act_blk_qual;
    rx_blk = ctrl[`LEDCTL_BIT_RX_BLK] & phy.link_up & phy.rx_active & act_blk_qual;
    blink_act = tx_blk | rx_blk
      | (ctrl[`LEDCTL_BIT_COL_BLK] & phy.link_up & phy.collision)
      | (ctrl[`LEDCTL_BIT_FAST_BLK] & link_fast)
      | (ctrl[`LEDCTL_BIT_SLOW_BLK] & link_slow);
    blink_wave = wave2;
    if (ctrl[`LEDCTL_BIT_FORCE_EN]) begin
      next_src = LEDCTL_SRC_FORCE;
      case (force_sel)
        LEDCTL_FORCE_BLINK2: next_led = wave2;
        LEDCTL_FORCE_BLINK1: next_led = wave1;
        LEDCTL_FORCE_ON: next_led = 1'b1;
        default: next_led = 1'b0;
      endcase
    end else if (phy.phy_active & phy.an_good_check) begin
      next_src = LEDCTL_SRC_ON;
      next_led = ctrl[`LEDCTL_BIT_TRY];
    end else if (blink_act) begin
      next_src = LEDCTL_SRC_BLINK;
      next_led = blink_wave;
    end else if (on_cond) begin
      next_src = LEDCTL_SRC_ON;
      next_led = 1'b1;
    end else begin
      next_src = LEDCTL_SRC_OFF;
      next_led = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led <= 1'b0;
      src <= LEDCTL_SRC_OFF;
    end else begin
      led <= next_led;
      src <= next_src;
    end
  end

  a_force_on_holds: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[`LEDCTL_BIT_FORCE_EN] && force_sel == LEDCTL_FORCE_ON) |=> led)
    else $error("forced on led is dark");
  a_force_off_holds: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[`LEDCTL_BIT_FORCE_EN] && force_sel == LEDCTL_FORCE_OFF) |=> !led)
    else $error("forced off led is lit");
  a_force_blink1: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[`LEDCTL_BIT_FORCE_EN] && force_sel == LEDCTL_FORCE_BLINK1) |=> led == $past(wave1))
    else $error("force blink 1 wrong wave");
  a_tx_stretch_load: assert property (@(posedge clk) disable iff (!rst_b)
    (phy.link_up && phy.tx_active) |=> tx_stretch == 32'(STRETCH_CYC))
    else $error("tx stretch not reloaded");
  a_rx_stretch_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (phy.link_up && phy.rx_active) |=> (rx_stretch != 32'h0) [*3])
    else $error("rx stretch ended early");
  a_try_state: assert property (@(posedge clk) disable iff (!rst_b)
    (!ctrl[`LEDCTL_BIT_FORCE_EN] && phy.phy_active && phy.an_good_check)
    |=> led == $past(ctrl[`LEDCTL_BIT_TRY]))
    else $error("link try led wrong");
  a_blink_wins: assert property (@(posedge clk) disable iff (!rst_b)
    (!ctrl[`LEDCTL_BIT_FORCE_EN] && !(phy.phy_active && phy.an_good_check) && blink_act)
    |=> src == LEDCTL_SRC_BLINK && led == $past(wave2))
    else $error("blink did not take priority");
  a_slow_on: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0010 && link_slow && !(phy.phy_active && phy.an_good_check)) |=> led)
    else $error("slow speed led dark");
  a_fast_on: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0020 && link_fast && !(phy.phy_active && phy.an_good_check)) |=> led)
    else $error("fast speed led dark");
  a_col_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0008 && phy.link_up && phy.collision && !phy.an_good_check)
    |=> src == LEDCTL_SRC_BLINK)
    else $error("collision did not blink");
  a_force_blink2: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[`LEDCTL_BIT_FORCE_EN] && force_sel == LEDCTL_FORCE_BLINK2) |=> led == $past(wave2))
    else $error("force blink 2 wrong wave");
  a_force_only: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[`LEDCTL_BIT_FORCE_EN] |=> src == LEDCTL_SRC_FORCE)
    else $error("force mode lost the led");
  a_fdx_on: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0800 && phy.link_up && phy.full_duplex && !phy.an_good_check) |=> led)
    else $error("full duplex led dark");
  a_fdx_dark: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0800 && !phy.full_duplex && !phy.an_good_check) |=> !led)
    else $error("full duplex led lit in half duplex");
  a_hdx_on: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0400 && phy.link_up && !phy.full_duplex && !phy.an_good_check) |=> led)
    else $error("half duplex led dark");
  a_hdx_dark: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0400 && phy.full_duplex && !phy.an_good_check) |=> !led)
    else $error("half duplex led lit in full duplex");
  a_fast_dark: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0020 && !link_fast && !phy.an_good_check) |=> !led)
    else $error("fast speed led lit without fast link");
  a_slow_dark: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0010 && !link_slow && !phy.an_good_check) |=> !led)
    else $error("slow speed led lit without slow link");
  a_tx_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h3200 && phy.link_up && phy.tx_active && !phy.an_good_check)
    |=> src == LEDCTL_SRC_BLINK && led == $past(wave2))
    else $error("tx activity did not blink");
  a_rx_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h3100 && phy.link_up && phy.rx_active && !phy.an_good_check)
    |=> src == LEDCTL_SRC_BLINK && led == $past(wave2))
    else $error("rx activity did not blink");
  a_tx_blink_qual: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0200 && !phy.an_good_check) |=> src != LEDCTL_SRC_BLINK)
    else $error("unqualified tx activity blinked");
  a_rx_blink_qual: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0100 && !phy.an_good_check) |=> src != LEDCTL_SRC_BLINK)
    else $error("unqualified rx activity blinked");
  a_dark_no_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h2300 && !phy.an_good_check) |=> !led)
    else $error("traffic blinked a dark led");
  a_lit_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0310 && link_slow && phy.tx_active && !phy.an_good_check)
    |=> src == LEDCTL_SRC_BLINK)
    else $error("traffic did not blink a lit led");
  a_tx_min_on: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0080 && tx_since < 32'(STRETCH_CYC) && !phy.an_good_check)
    |=> led)
    else $error("tx activity led went dark early");
  a_rx_min_on: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0040 && rx_since < 32'(STRETCH_CYC) && !phy.an_good_check)
    |=> led)
    else $error("rx activity led went dark early");
  a_tx_stretch_end: assert property (@(posedge clk) disable iff (!rst_b)
    (tx_since >= 32'(STRETCH_CYC)) |-> tx_stretch == 32'h0)
    else $error("tx stretch outlived its count");
  a_rx_stretch_end: assert property (@(posedge clk) disable iff (!rst_b)
    (rx_since >= 32'(STRETCH_CYC)) |-> rx_stretch == 32'h0)
    else $error("rx stretch outlived its count");
  a_fast_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0004 && link_fast && !phy.an_good_check)
    |=> src == LEDCTL_SRC_BLINK && led == $past(wave2))
    else $error("fast speed did not blink");
  a_slow_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0002 && link_slow && !phy.an_good_check)
    |=> src == LEDCTL_SRC_BLINK && led == $past(wave2))
    else $error("slow speed did not blink");
  a_fast_blink_off: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0004 && !link_fast && !phy.an_good_check) |=> !led)
    else $error("fast speed blink without fast link");
  a_col_dark: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0008 && !(phy.link_up && phy.collision) && !phy.an_good_check) |=> !led)
    else $error("collision blink without collision");
  a_all_off: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0000 && !phy.an_good_check) |=> !led && src == LEDCTL_SRC_OFF)
    else $error("led lit with nothing enabled");
  a_try_over_blink: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl == 16'h0005 && phy.phy_active && phy.an_good_check) |=> led)
    else $error("blink overrode link try");
  a_blink_cfg_write: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `LEDCTL_OFF_BLINK) |=> blink_cfg == $past(reg_wdata))
    else $error("blink config write lost");
  a_status_ro: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `LEDCTL_OFF_STATUS)
    |=> ctrl == $past(ctrl) && blink_cfg == $past(blink_cfg))
    else $error("status write changed a register");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data stood without a read");
endmodule
`default_nettype wire

// file: logic/ledctl_consts.svh
// offsets, field positions, reset values and timing counts of the first led controller
`ifndef LEDCTL_CONSTS_SVH
`define LEDCTL_CONSTS_SVH
`define LEDCTL_ADDR_W 16
`define LEDCTL_OFF_CTRL 16'h40c0
`define LEDCTL_OFF_BLINK 16'h40c2
`define LEDCTL_OFF_STATUS 16'h40c4
`define LEDCTL_CTRL_RESET 16'h0311
`define LEDCTL_BLINK_RESET 16'hec75
`define LEDCTL_BIT_FORCE_EN 15
`define LEDCTL_BIT_FORCE_HI 14
`define LEDCTL_BIT_FORCE_LO 13
`define LEDCTL_BIT_ACT_IND 12
`define LEDCTL_BIT_FDX_ON 11
`define LEDCTL_BIT_HDX_ON 10
`define LEDCTL_BIT_TX_BLK 9
`define LEDCTL_BIT_RX_BLK 8
`define LEDCTL_BIT_TX_ON 7
`define LEDCTL_BIT_RX_ON 6
`define LEDCTL_BIT_FAST_ON 5
`define LEDCTL_BIT_SLOW_ON 4
`define LEDCTL_BIT_COL_BLK 3
`define LEDCTL_BIT_FAST_BLK 2
`define LEDCTL_BIT_SLOW_BLK 1
`define LEDCTL_BIT_TRY 0
`define LEDCTL_FREQ1_HI 11
`define LEDCTL_FREQ1_LO 8
`define LEDCTL_FREQ2_HI 7
`define LEDCTL_FREQ2_LO 4
`define LEDCTL_CLK_MHZ 200
`define LEDCTL_STRETCH_MS 10
`define LEDCTL_STRETCH_CYC (`LEDCTL_STRETCH_MS * 1000 * `LEDCTL_CLK_MHZ)
`define LEDCTL_BLINK_BASE_CYC 2000000
`endif

// file: logic/ledctl_pkg.sv
// types shared by the first led controller
package ledctl_pkg;
  typedef struct packed {
    logic link_up;
    logic fast_speed;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic collision;
    logic an_good_check;
    logic phy_active;
  } ledctl_phy_s;
  typedef enum logic [1:0] {
    LEDCTL_FORCE_OFF,
    LEDCTL_FORCE_ON,
    LEDCTL_FORCE_BLINK1,
    LEDCTL_FORCE_BLINK2
  } ledctl_force_e;
  typedef enum logic [1:0] {
    LEDCTL_SRC_OFF,
    LEDCTL_SRC_FORCE,
    LEDCTL_SRC_BLINK,
    LEDCTL_SRC_ON
  } ledctl_src_e;
endpackage

// file: logic/ledctl_blink_gen.sv
// square-wave blink generator selected by a four-bit frequency code
`timescale 1ns/100ps
`default_nettype none
`include "ledctl_consts.svh"
module ledctl_blink_gen #(
  parameter int BASE_CYC = `LEDCTL_BLINK_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // frequency code, higher code blinks faster
  input wire logic [3:0] freq_sel,
  // blink waveform
  output logic wave
);
  logic [31:0] count;
  logic [31:0] half_period;

  // simple stand-in for the rate table: half period shrinks with the code
  always_comb begin
    half_period = BASE_CYC / (32'd1 + {28'h0000000, freq_sel});
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h00000000;
      wave <= 1'b0;
    end else if (count + 32'd1 >= half_period) begin
      count <= 32'h00000000;
      wave <= ~wave;
    end else begin
      count <= count + 32'd1;
    end
  end
endmodule
`default_nettype wire

// file: dv/ledctl_lamp.sv
// lamp model on the led pin, counting level changes inside a window
`timescale 1ns/100ps
`default_nettype none
module ledctl_lamp (
  // clock
  input wire logic clk,
  // led pin and window clear
  input wire logic led,
  input wire logic clr,
  output logic [15:0] flips
);
  logic last;
  always_ff @(posedge clk) begin
    last <= led;
    if (clr) begin
      flips <= 16'h0;
    end else if (led !== last) begin
      flips <= flips + 16'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/test_ledctl_top.sv
// self-checking bench of the first led controller
`timescale 1ns/100ps
`default_nettype none
module test_ledctl_top
  import ledctl_pkg::*;
;
  localparam logic [15:0] CT = 16'h40c0;
  localparam logic [15:0] BL = 16'h40c2;
  localparam logic [15:0] ST = 16'h40c4;
  logic clk, rst_b, reg_wr, reg_rd, led, clr;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, flips, n1;
  ledctl_phy_s phy;
  int err_count, tests_run, cyc;
  // short counts keep the stretch and blink periods within a few dozen cycles
  ledctl_top #(.STRETCH_CYC(20), .BLINK_BASE_CYC(8)) i_ledctl_top (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .phy_in(phy), .led(led));
  ledctl_lamp i_ledctl_lamp (.clk(clk), .led(led), .clr(clr), .flips(flips));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  // phy changes reach the pin three edges later, so six gives margin
  task automatic setp(input logic [7:0] p);
    @(posedge clk);
    phy <= ledctl_phy_s'(p);
    repeat (6) @(posedge clk);
  endtask
  task automatic led_is(input logic e);
    repeat (3) @(posedge clk);
    #1 chk("led", {15'h0, led}, {15'h0, e});
  endtask
  task automatic win(output logic [15:0] n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (64) @(posedge clk);
    #1 n = flips;
  endtask
  task automatic blinks(input logic e);
    logic [15:0] n;
    win(n);
    chk("flips", {15'h0, n >= 16'h3}, {15'h0, e});
  endtask
  task automatic t_regs();
    rd(CT, 16'h0311);
    rd(BL, 16'hec75);
    wr(16'h40c6, 16'hffff);
    rd(16'h40c6, 16'h0);
    wr(BL, 16'h0030);
    rd(BL, 16'h0030);
    $display("test regs done");
  endtask
  task automatic t_speed();
    setp(8'h80); led_is(1'b1);
    setp(8'hc0); led_is(1'b0);
    wr(CT, 16'h0020); led_is(1'b1);
    rd(ST, 16'h0007);
    wr(ST, 16'h0000);
    rd(ST, 16'h0007);
    wr(CT, 16'h0800); setp(8'ha0); led_is(1'b1);
    wr(CT, 16'h0400); led_is(1'b0);
    setp(8'h80); led_is(1'b1);
    $display("test speed done");
  endtask
  task automatic t_force();
    logic [15:0] n2;
    wr(CT, 16'h8010); led_is(1'b0);
    wr(CT, 16'ha000); led_is(1'b1);
    wr(CT, 16'hc000); blinks(1'b1);
    wr(CT, 16'he000); blinks(1'b1);
    wr(CT, 16'hc000); win(n1);
    wr(BL, 16'h0330); win(n2);
    chk("mode1 rate", {15'h0, n2 > n1}, 16'h1);
    wr(BL, 16'h0030);
    $display("test force done");
  endtask
  task automatic t_blink();
    wr(CT, 16'h0002); blinks(1'b1);
    wr(CT, 16'h0004); blinks(1'b0);
    setp(8'hc0); blinks(1'b1);
    wr(CT, 16'h0008); blinks(1'b0);
    setp(8'hc4); blinks(1'b1);
    $display("test blink done");
  endtask
  task automatic t_act();
    setp(8'h80);
    wr(CT, 16'h0080);
    @(posedge clk) phy <= ledctl_phy_s'(8'h90);
    @(posedge clk) phy <= ledctl_phy_s'(8'h80);
    repeat (9) @(posedge clk); led_is(1'b1);
    rd(ST, 16'h0017);
    repeat (40) @(posedge clk); led_is(1'b0);
    wr(CT, 16'h0040);
    @(posedge clk) phy <= ledctl_phy_s'(8'h88);
    @(posedge clk) phy <= ledctl_phy_s'(8'h80);
    repeat (9) @(posedge clk); led_is(1'b1);
    rd(ST, 16'h000f);
    repeat (40) @(posedge clk); led_is(1'b0);
    $display("test activity done");
  endtask
  task automatic t_actblk();
    wr(CT, 16'h3200); setp(8'h90); blinks(1'b1);
    wr(CT, 16'h2100); setp(8'h88); blinks(1'b0);
    wr(CT, 16'h3100); blinks(1'b1);
    wr(CT, 16'h0110); blinks(1'b1);
    $display("test activity blink done");
  endtask
  task automatic t_try();
    wr(CT, 16'h0331); setp(8'h03); led_is(1'b1);
    wr(CT, 16'h0330); led_is(1'b0);
    wr(CT, 16'h0331); setp(8'h02); led_is(1'b0);
    $display("test link try done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // the whole run takes about twelve hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    rst_b = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    clr = 1'b1;
    phy = ledctl_phy_s'(8'h00);
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_speed();
    t_force();
    t_blink();
    t_act();
    t_actblk();
    t_try();
    end_sim();
  end
endmodule
`default_nettype wire
